//--- logic/scaler_pkg.sv
// constants for the strain result scaler and mode control block
// assumes a 32-bit axi4-lite register bus and byte addresses
package scaler_pkg;
  // ****************************************************
  // register byte offsets
  // ****************************************************
  localparam logic [7:0] OFF_CFG0 = 8'h00;
  localparam logic [7:0] OFF_CFG1 = 8'h04;
  localparam logic [7:0] OFF_CFG2 = 8'h08;
  localparam logic [7:0] OFF_CFG8 = 8'h20;
  localparam logic [7:0] OFF_CFG9 = 8'h24;
  localparam logic [7:0] OFF_CFG10 = 8'h28;
  localparam logic [7:0] OFF_FACTOR_A = 8'h40;
  localparam logic [7:0] OFF_FACTOR_B = 8'h44;
  localparam logic [7:0] OFF_MODE = 8'h48;
  localparam logic [7:0] OFF_CYCLE = 8'h4c;
  localparam logic [7:0] OFF_CMD = 8'h50;
  localparam logic [7:0] OFF_STATUS = 8'h54;
  localparam logic [7:0] OFF_RESULT0 = 8'h58;
  localparam logic [7:0] OFF_RESULT1 = 8'h5c;
  localparam logic [7:0] OFF_TDC = 8'h60;
  // ****************************************************
  // field positions
  // ****************************************************
  localparam int BIT_SCALE_A_EN = 17;
  localparam int BIT_SCALE_B_EN = 0;
  localparam int BIT_DOUBLE = 0;
  localparam int BIT_COMB_LO = 1;
  localparam int BIT_RANGE1 = 3;
  localparam int BIT_CYC_FAST = 4;
  localparam int BIT_SINGLE = 5;
  localparam int BIT_CMD_START = 0;
  // ****************************************************
  // codes and reset values
  // ****************************************************
  localparam int FACTOR_W = 24;
  localparam int FRAC_W = 16;
  localparam logic [23:0] FACTOR_ONE = 24'h010000;
  localparam logic [1:0] COMB_SUM = 2'h1;
  localparam logic [1:0] COMB_DIFF = 2'h2;
  localparam logic [1:0] SUB_OFF = 2'h0;
  localparam logic [1:0] SUB_PLAIN = 2'h1;
  localparam logic [1:0] SUB_TWO_SW = 2'h3;
  localparam logic [31:0] CYCLE_RST = 32'h00000004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : scaler_pkg

//--- logic/strain_result_scaler.sv
// result scaling datapath, measurement sequencing and mode registers
// assumes a front end that returns raw bridge results after meas_start,
// and tick pulses from the slow and fast oscillators synchronous to aclk
//
// Operation
// [R1] factors are 24-bit unsigned, 8 integer and 16 fraction bits
// [R2] first factor applied only while config 0 bit 17 is set
// [R3] second factor used only while config 8 bit 0 is set
// [R4] single bridge, both factors: half one by first, half two by second
// [R5] per-half scaling happens before any sum or difference merge
// [R6] double bridge: full bridge one by first, two by second factor
// [R7] unmerged halves of one full bridge share the same factor
// [R8] coin cell supply: host sets calibration averaging 0, interval 1
// [R9] range 1 times discharge directly, counting range two to twentieth
// [R10] range 1 cycle time from slow oscillator, or fast when selected
// [R11] host sets switch-resistance averaging 1, gain correction off
// [R12] host may set charge start sync and delay bits for noise
// [R13] host enables single-arm reference bit for fixed reference capacitor
// [R14] host sets floating capacitance bit in config 1 for shared resistor
// [R15] grounded capacitors: host sets only trigger-on-charge extra
// [R16] compensated mode drives switch alternating sense and reference
// [R17] host uses half-bridge mode with one capacitor pair when compensating
// [R18] submode 0 off, 1 plain, 2 compensated, 3 two switches
// [R19] compensated mode removes parasitic and delay offset from results
// [R20] single conversion measures once then waits for next trigger
// [R21] cleared enable passes the result as if multiplied by one; a cleared second enable uses the first factor instead
`timescale 1ns/1ps
module strain_result_scaler
  import scaler_pkg::*;
#(
  parameter int TDC_W = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slow_tick,
  input wire logic fast_osc_tick,
  input wire logic start_trigger,
  input wire logic discharge_active,
  input wire logic raw_valid,
  input wire logic signed [23:0] raw_hb0,
  input wire logic signed [23:0] raw_hb1,
  input wire logic signed [23:0] raw_hb2,
  input wire logic signed [23:0] raw_hb3,
  output logic meas_start,
  output logic switch_select,
  output logic switch_enable,
  output logic switch_sense_on,
  output logic switch_ref_on,
  output logic signed [31:0] result0,
  output logic signed [31:0] result1,
  output logic result_valid
);
  import scaler_pkg::*;

  typedef enum logic [1:0] {st_idle, st_wait, st_scale, st_out} seq_e;

  // ****************************************************
  // scaling arithmetic
  // ****************************************************
  // [R1] unsigned 8.16 factor times signed raw, fraction dropped
  function automatic logic signed [31:0] scale(
    input logic signed [23:0] raw, input logic [23:0] f);
    logic signed [48:0] p;
    p = raw * $signed({1'b0, f});
    return p[FRAC_W+31:FRAC_W];
  endfunction : scale

  function automatic logic [31:0] merge_strb(
    input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_strb

  logic [31:0] cfg0_q, cfg1_q, cfg2_q, cfg8_q, cfg9_q, cfg10_q;
  logic [23:0] factor_a_q, factor_b_q;
  logic [5:0] mode_q;
  logic [31:0] cycle_q;
  logic [7:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held_q, w_held_q;
  logic do_wr, wr_hit, rd_hit, sw_start;
  logic [31:0] rd_word;
  seq_e state_q;
  logic [1:0] phase_q;
  logic pend_q;
  logic [31:0] cyc_cnt_q;
  logic [TDC_W-1:0] tdc_q;
  logic signed [23:0] r0_q, r1_q, r2_q, r3_q, zero_q;
  logic signed [31:0] p0_q, p1_q, p2_q, p3_q;
  logic [23:0] eff_a, eff_b, f_hb1;
  logic [1:0] submode, comb;
  logic comp_on, comp_corr, last_phase, trig_src, ref_tick;

  assign submode = cfg9_q[1:0];
  assign comb = mode_q[BIT_COMB_LO +: 2];
  assign comp_on = submode != SUB_OFF;
  assign comp_corr = comp_on && submode != SUB_PLAIN;
  assign last_phase = comp_corr ? phase_q == 2'h2 :
                      comp_on ? phase_q == 2'h1 : 1'b1;

  // ****************************************************
  // axi4-lite slave
  // ****************************************************
  assign do_wr = aw_held_q && w_held_q && !s_axi_bvalid;
  always_comb begin
    wr_hit = 1'b1;
    unique case (awaddr_q)
      OFF_CFG0, OFF_CFG1, OFF_CFG2, OFF_CFG8, OFF_CFG9, OFF_CFG10,
      OFF_FACTOR_A, OFF_FACTOR_B, OFF_MODE, OFF_CYCLE, OFF_CMD: ;
      default: wr_hit = 1'b0;
    endcase
  end
  assign sw_start = do_wr && awaddr_q == OFF_CMD && wstrb_q[0] &&
                    wdata_q[BIT_CMD_START];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_word = '0;
    unique case (araddr_q)
      OFF_CFG0: rd_word = cfg0_q;
      OFF_CFG1: rd_word = cfg1_q;
      OFF_CFG2: rd_word = cfg2_q;
      OFF_CFG8: rd_word = cfg8_q;
      OFF_CFG9: rd_word = cfg9_q;
      OFF_CFG10: rd_word = cfg10_q;
      OFF_FACTOR_A: rd_word = {8'h00, factor_a_q};
      OFF_FACTOR_B: rd_word = {8'h00, factor_b_q};
      OFF_MODE: rd_word = {26'h0000000, mode_q};
      OFF_CYCLE: rd_word = cycle_q;
      OFF_CMD: rd_word = '0;
      OFF_STATUS: rd_word = {27'h0000000, pend_q, phase_q, state_q};
      OFF_RESULT0: rd_word = result0;
      OFF_RESULT1: rd_word = result1;
      OFF_TDC: rd_word = {{(32-TDC_W){1'b0}}, tdc_q};
      default: rd_hit = 1'b0;
    endcase
  end

  // read answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      araddr_q <= '0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        araddr_q <= s_axi_araddr;
        s_axi_arready <= 1'b0;
      end else if (!s_axi_arready && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************************
  // configuration registers
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg0_q <= '0;
      cfg1_q <= '0;
      cfg2_q <= '0;
      cfg8_q <= '0;
      cfg9_q <= '0;
      cfg10_q <= '0;
      factor_a_q <= FACTOR_ONE;
      factor_b_q <= FACTOR_ONE;
      mode_q <= '0;
      cycle_q <= CYCLE_RST;
    end else if (do_wr) begin
      unique case (awaddr_q)
        OFF_CFG0: cfg0_q <= merge_strb(cfg0_q, wdata_q, wstrb_q);
        OFF_CFG1: cfg1_q <= merge_strb(cfg1_q, wdata_q, wstrb_q);
        OFF_CFG2: cfg2_q <= merge_strb(cfg2_q, wdata_q, wstrb_q);
        OFF_CFG8: cfg8_q <= merge_strb(cfg8_q, wdata_q, wstrb_q);
        OFF_CFG9: cfg9_q <= merge_strb(cfg9_q, wdata_q, wstrb_q);
        OFF_CFG10: cfg10_q <= merge_strb(cfg10_q, wdata_q, wstrb_q);
        OFF_FACTOR_A: factor_a_q <= FACTOR_W'(merge_strb(
          {8'h00, factor_a_q}, wdata_q, wstrb_q));
        OFF_FACTOR_B: factor_b_q <= FACTOR_W'(merge_strb(
          {8'h00, factor_b_q}, wdata_q, wstrb_q));
        OFF_MODE: mode_q <= 6'(merge_strb(
          {26'h0000000, mode_q}, wdata_q, wstrb_q));
        OFF_CYCLE: cycle_q <= merge_strb(cycle_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // ****************************************************
  // cycle timer and trigger
  // ****************************************************
  // [R10] fast reference only selectable in range 1
  assign ref_tick = (mode_q[BIT_RANGE1] && mode_q[BIT_CYC_FAST]) ?
                    fast_osc_tick : slow_tick;
  // [R20] single conversion waits for an external or software start
  assign trig_src = mode_q[BIT_SINGLE] ? (start_trigger || sw_start) :
                    (ref_tick && cyc_cnt_q + 32'h1 >= cycle_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_cnt_q <= '0;
    end else if (ref_tick) begin
      cyc_cnt_q <= (cyc_cnt_q + 32'h1 >= cycle_q) ? '0 : cyc_cnt_q + 32'h1;
    end
  end

  // a trigger landing on the consuming cycle stays pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 1'b0;
    end else if (trig_src) begin
      pend_q <= 1'b1;
    end else if (state_q == st_idle) begin
      pend_q <= 1'b0;
    end
  end

  // ****************************************************
  // range 1 discharge timing
  // ****************************************************
  // [R9] direct count at full rate, saturating at the counting range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tdc_q <= '0;
    end else if (meas_start) begin
      tdc_q <= '0;
    end else if (mode_q[BIT_RANGE1] && discharge_active && !(&tdc_q)) begin
      tdc_q <= tdc_q + 1'b1;
    end
  end

  // ****************************************************
  // measurement sequencer
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= st_idle;
      phase_q <= '0;
      meas_start <= 1'b0;
      r0_q <= '0;
      r1_q <= '0;
      r2_q <= '0;
      r3_q <= '0;
      zero_q <= '0;
    end else begin
      meas_start <= 1'b0;
      unique case (state_q)
        st_idle: begin
          phase_q <= '0;
          if (pend_q) begin
            meas_start <= 1'b1;
            state_q <= st_wait;
          end
        end
        st_wait: begin
          if (raw_valid) begin
            if (!comp_on) begin
              r0_q <= raw_hb0;
              r1_q <= raw_hb1;
              r2_q <= raw_hb2;
              r3_q <= raw_hb3;
              zero_q <= '0;
            end else begin
              // [R16] sense, then reference, then switch-off baseline
              unique case (phase_q)
                2'h0: r0_q <= raw_hb0;
                2'h1: r1_q <= raw_hb0;
                default: zero_q <= raw_hb0;
              endcase
              if (!comp_corr) begin
                zero_q <= '0;
              end
            end
            if (last_phase) begin
              state_q <= st_scale;
            end else begin
              phase_q <= phase_q + 2'h1;
              meas_start <= 1'b1;
            end
          end
        end
        st_scale: state_q <= st_out;
        st_out: state_q <= st_idle;
      endcase
    end
  end

  // [R18] submode decode onto the switch control lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      switch_select <= 1'b0;
      switch_enable <= 1'b0;
      switch_sense_on <= 1'b0;
      switch_ref_on <= 1'b0;
    end else begin
      switch_select <= comp_on && phase_q == 2'h1;
      switch_enable <= comp_on && submode != SUB_TWO_SW &&
                       phase_q != 2'h2;
      switch_sense_on <= submode == SUB_TWO_SW && phase_q == 2'h0;
      switch_ref_on <= submode == SUB_TWO_SW && phase_q == 2'h1;
    end
  end

  // ****************************************************
  // scaling and merge
  // ****************************************************
  // [R2] [R21] disabled factor acts as one
  assign eff_a = cfg0_q[BIT_SCALE_A_EN] ? factor_a_q : FACTOR_ONE;
  // [R3] second factor falls back to the first when disabled
  assign eff_b = cfg8_q[BIT_SCALE_B_EN] ? factor_b_q : eff_a;
  // [R4] [R7] second half uses its own factor only when merged
  assign f_hb1 = (!mode_q[BIT_DOUBLE] && comb != '0 && !comp_on) ?
                 eff_b : eff_a;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p0_q <= '0;
      p1_q <= '0;
      p2_q <= '0;
      p3_q <= '0;
    end else if (state_q == st_scale) begin
      // [R19] baseline removes parasitic charge and comparator delay
      p0_q <= scale(r0_q - zero_q, eff_a);
      p1_q <= scale(r1_q - zero_q, f_hb1);
      // [R6] second full bridge takes the second factor
      p2_q <= scale(r2_q, eff_b);
      p3_q <= scale(r3_q, eff_b);
    end
  end

  // [R5] merge works on already scaled halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result0 <= '0;
      result1 <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= state_q == st_out;
      if (state_q == st_out) begin
        if (comp_on || comb == '0) begin
          result0 <= p0_q;
          result1 <= mode_q[BIT_DOUBLE] ? p2_q : p1_q;
        end else if (comb == COMB_DIFF) begin
          result0 <= p0_q - p1_q;
          result1 <= p2_q - p3_q;
        end else begin
          result0 <= p0_q + p1_q;
          result1 <= p2_q + p3_q;
        end
      end
    end
  end
endmodule : strain_result_scaler

//--- testbench/scaler_monitor.sv
// checker on the scaler's bus, switch and result ports
// assumes one clock and aresetn synchronous, active low
`timescale 1ns/1ps
module scaler_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic raw_valid,
  input wire logic meas_start,
  input wire logic switch_select,
  input wire logic switch_enable,
  input wire logic switch_sense_on,
  input wire logic switch_ref_on,
  input wire logic signed [31:0] result0,
  input wire logic signed [31:0] result1,
  input wire logic result_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ******
  // bus handshakes
  // ******
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_soon;
    ##[1:2] s_axi_bvalid;
  endsequence
  wr_answer_a: assert property (wr_both |-> b_soon)
    else $error("bresp late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |->
    ##[1:2] s_axi_rvalid) else $error("rdata late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read while busy");
  // ******
  // results and switch
  // ******
  // scale then merge
  res_pipe_a: assert property (result_valid |-> $past(raw_valid, 3))
    else $error("result timing");
  res_hold_a: assert property (!result_valid |->
    $stable(result0) && $stable(result1))
    else $error("result moved");
  pulse_pair_a: assert property ((meas_start |=> !meas_start) and
    (result_valid |=> !result_valid))
    else $error("long pulse");
  sw_phase_a: assert property ((switch_sense_on |-> !switch_select) and
    (switch_ref_on |-> switch_select))
    else $error("switch leg");
  sw_excl_a: assert property (!(switch_sense_on && switch_ref_on))
    else $error("both legs on");
  sw_kind_a: assert property (switch_enable |->
    !switch_sense_on && !switch_ref_on)
    else $error("kinds mixed");
endmodule : scaler_monitor

bind strain_result_scaler scaler_monitor mon (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .raw_valid, .meas_start,
  .switch_select, .switch_enable, .switch_sense_on, .switch_ref_on,
  .result0, .result1, .result_valid);

//--- testbench/frontend_model.sv
// behavioural front end: answers each measurement request with raw data
// assumes meas_start and result_valid are one-cycle pulses on aclk
`timescale 1ns/1ps
module frontend_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic meas_start,
  input wire logic result_valid,
  input wire logic [7:0] dly,
  input wire logic [3:0][23:0] v,
  output logic discharge_active,
  output logic raw_valid,
  output logic signed [3:0][23:0] hb
);
  logic busy_q;
  logic [7:0] left_q;
  logic [1:0] phase_q;
  // ******
  // discharge window, dly cycles long
  // ******
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'h0;
      left_q <= 8'h00;
      raw_valid <= 1'h0;
    end else begin
      raw_valid <= 1'h0;
      if (meas_start) begin
        busy_q <= 1'h1;
        left_q <= dly;
      end else if (busy_q) begin
        left_q <= left_q - 8'h01;
        if (left_q == 8'h01) begin
          busy_q <= 1'h0;
          raw_valid <= 1'h1;
        end
      end
    end
  end
  assign discharge_active = busy_q;
  // phase index tells sense, reference and baseline apart in the data
  always_ff @(posedge aclk) begin
    if (!aresetn || result_valid) begin
      phase_q <= 2'h0;
    end else if (raw_valid) begin
      phase_q <= phase_q + 2'h1;
    end
  end
  // inverted data outside a delivery
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hb[i] = raw_valid ? v[i] + {10'h0, phase_q, 12'h0} : ~v[i];
    end
  end
endmodule : frontend_model

//--- testbench/strain_result_scaler_bench.sv
// self-checking bench for the result scaler and mode control
// assumes the front end model answers every meas_start
`timescale 1ns/1ps
module strain_result_scaler_bench;
  import scaler_pkg::*;
  localparam logic [23:0] A_F = 24'h018000;
  localparam logic [23:0] B_F = 24'h008000;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic slow_tick = 1'h0, fast_osc_tick = 1'h0, start_trigger = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic discharge_active, raw_valid, meas_start, result_valid;
  logic switch_select, switch_enable, switch_sense_on, switch_ref_on;
  logic signed [31:0] result0, result1;
  logic signed [3:0][23:0] hb;
  logic [3:0][23:0] v = {24'h002000, 24'h000100, 24'hfff000, 24'h000400};
  logic [7:0] dly = 8'h05;
  int miscompares = 0, total_checks = 0, starts = 0;

  strain_result_scaler dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .slow_tick, .fast_osc_tick, .start_trigger,
    .discharge_active, .raw_valid, .raw_hb0(hb[0]), .raw_hb1(hb[1]),
    .raw_hb2(hb[2]), .raw_hb3(hb[3]), .meas_start, .switch_select,
    .switch_enable, .switch_sense_on, .switch_ref_on, .result0,
    .result1, .result_valid);
  frontend_model fe (.aclk, .aresetn, .meas_start, .result_valid, .dly,
    .v, .discharge_active, .raw_valid, .hb);

  initial begin
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (meas_start) starts <= starts + 1;
  end
  // ******
  // shared tasks
  // ******
  task automatic chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic wait_res;
    repeat (400) begin
      @(posedge aclk);
      if (result_valid) return;
    end
  endtask : wait_res
  task automatic run;
    wr(OFF_CMD, 32'h1, r);
    wait_res;
  endtask : run
  task automatic tick(input logic f, input int n);
    repeat (n) begin
      @(posedge aclk);
      {fast_osc_tick, slow_tick} <= f ? 2'h2 : 2'h1;
      @(posedge aclk);
      {fast_osc_tick, slow_tick} <= 2'h0;
      repeat (4) @(posedge aclk);
    end
  endtask : tick
  function automatic logic signed [31:0] sc(input logic signed [23:0] x,
    input logic [23:0] f);
    logic signed [48:0] p;
    p = x * $signed({1'h0, f});
    return p[47:16];
  endfunction : sc
  // ******
  // scenarios
  // ******
  task automatic t_reset;
    rd(OFF_FACTOR_A, d, r);
    chk("factor_a", d, {8'h0, FACTOR_ONE});
    rd(OFF_FACTOR_B, d, r);
    chk("factor_b", d, {8'h0, FACTOR_ONE});
    rd(OFF_CYCLE, d, r);
    chk("cycle", d, CYCLE_RST);
    rd(8'h7c, d, r);
    chk("hole_rresp", 32'(r), 32'(RESP_SLVERR));
    chk("hole_rdata", d, 32'h0);
    wr(8'h7c, 32'hffffffff, r);
    chk("hole_bresp", 32'(r), 32'(RESP_SLVERR));
    rd(OFF_CMD, d, r);
    chk("cmd_read", d, 32'h0);
    wr(OFF_CFG2, 32'h1, r);
    rd(OFF_CFG2, d, r);
    chk("calc_interval", d, 32'h1);
  endtask : t_reset
  task automatic t_scale;
    logic [4:0] cs [6] = '{5'h00, 5'h10, 5'h19, 5'h1c, 5'h1e, 5'h0c};
    logic signed [31:0] s0, s1, s2, s3, e0, e1;
    logic [23:0] fa, fb;
    wr(OFF_FACTOR_A, {8'h0, A_F}, r);
    wr(OFF_FACTOR_B, {8'h0, B_F}, r);
    // each code: {first on, second on, double, combine[1:0]}
    for (int i = 0; i < 6; i++) begin
      wr(OFF_CFG0, 32'(cs[i][4]) << BIT_SCALE_A_EN, r);
      wr(OFF_CFG8, 32'(cs[i][3]), r);
      wr(OFF_MODE, {26'h0, 3'h4, cs[i][1:0], cs[i][2]}, r);
      run;
      fa = cs[i][4] ? A_F : FACTOR_ONE;
      fb = cs[i][3] ? B_F : fa;
      s0 = sc(v[0], fa);
      s1 = sc(v[1], cs[i][2] ? fa : fb);
      s2 = sc(v[2], fb);
      s3 = sc(v[3], fb);
      if (cs[i][1:0] == 2'h0) begin
        e0 = s0;
        e1 = cs[i][2] ? s2 : sc(v[1], fa);
      end else begin
        e0 = cs[i][1:0] == COMB_SUM ? s0 + s1 : s0 - s1;
        e1 = cs[i][1:0] == COMB_SUM ? s2 + s3 : s2 - s3;
      end
      chk("result0", result0, e0);
      chk("result1", result1, e1);
    end
    rd(OFF_TDC, d, r);
    chk("tdc_off", d, 32'h0);
  endtask : t_scale
  task automatic t_comp;
    logic [3:0] sw [4] = '{4'h0, 4'h4, 4'h4, 4'h2};
    logic [31:0] e0, e1;
    wr(OFF_CFG0, 32'h0, r);
    wr(OFF_CFG8, 32'h0, r);
    // host bits at reset, half bridge
    wr(OFF_MODE, 32'h20, r);
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CFG9, 32'(s), r);
      run;
      e0 = s < 2 ? 32'h400 : 32'hffffe000;
      e1 = s == 1 ? 32'h1400 : 32'hfffff000;
      chk("comp_result0", result0, e0);
      chk("comp_result1", result1, e1);
      repeat (3) @(posedge aclk);
      chk("switches", {28'h0, switch_select, switch_enable,
        switch_sense_on, switch_ref_on}, {28'h0, sw[s]});
    end
    wr(OFF_CFG9, 32'h0, r);
  endtask : t_comp
  task automatic t_tdc;
    dly <= 8'h28;
    wr(OFF_MODE, 32'h28, r);
    run;
    rd(OFF_TDC, d, r);
    chk("tdc_count", d, 32'h28);
    dly <= 8'h05;
  endtask : t_tdc
  task automatic t_single;
    int n0;
    wr(OFF_MODE, 32'h20, r);
    n0 = starts;
    tick(1'h0, 8);
    @(posedge aclk);
    start_trigger <= 1'h1;
    @(posedge aclk);
    start_trigger <= 1'h0;
    wait_res;
    repeat (60) @(posedge aclk);
    chk("single_starts", 32'(starts - n0), 32'h1);
  endtask : t_single
  task automatic t_cycle;
    int n0;
    for (int f = 1; f >= 0; f--) begin
      wr(OFF_MODE, f ? 32'h18 : 32'h08, r);
      n0 = starts;
      tick(f == 0, 8);
      chk("wrong_ref", 32'(starts - n0), 32'h0);
      tick(f == 1, 4);
      wait_res;
      chk("cycle_starts", 32'(starts - n0), 32'h1);
    end
    wr(OFF_MODE, 32'h20, r);
  endtask : t_cycle
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_scale;
    t_comp;
    t_tdc;
    t_single;
    t_cycle;
    tally_and_finish;
  end
endmodule : strain_result_scaler_bench
